/* File: dmc_cache.v */
// Purpose: cache lookup: address split, parallel tag and data read, hit
// Assumes: requester holds a miss until the fill logic outside finishes
// Notes:   two-cycle lookup; hit and data valid two cycles after the request
`timescale 1ns/100ps
`include "dmc_consts.vh"
// Operation
// - split address into tag, index, offset
// - field widths from log2 of sizes
// - index plus offset covers cache capacity
// - line is power-of-two bytes
// - index reads stored tag
// - compare tag, check status together
// - index and offset read data word
// - hit only on match and valid
// - miss deasserts hit, requester refetches
// - access time is slower path
// - direct mapping wraps modulo line count
// - two-way gives two banks same index
// - n ways give n candidate places
// - fully associative searches every entry
// - physical mode translates before lookup
// - virtual mode translates beside lookup
// - dual tags cross-check for aliases
// - hit ORs ways, decoder picks data
module dmc_cache #(
  parameter AW     = `DMC_ADDR_W,
  parameter DW     = `DMC_DATA_W,
  parameter LBYTES = `DMC_LINE_BYTES,
  parameter LINES  = `DMC_NUM_LINES,
  parameter WAYS   = `DMC_NUM_WAYS
) (
  input  wire          clk,
  input  wire          sys_rst,
  // reference from the processor
  input  wire          virt_mode,
  input  wire          req_valid,
  input  wire [AW-1:0] req_addr,
  input  wire [AW-1:0] req_paddr,
  input  wire          req_write,
  // line fill from main memory
  input  wire          fill_we,
  input  wire [AW-1:0] fill_addr,
  input  wire [AW-1:0] fill_paddr,
  input  wire [DW-1:0] fill_data,
  input  wire          fill_last,
  input  wire [7:0]    fill_way,
  // lookup result, all registered
  output reg           rsp_valid_ff,
  output reg           hit_ff,
  output reg  [DW-1:0] rd_data_ff,
  output reg           alias_ff,
  output reg           line_modified_bit_ff,
  output reg  [AW-1:0] miss_paddr_ff
);
  // ceil log2 helper used for every field width
  function integer clog2f;
    input integer v;
    integer n;
    begin
      n = 0;
      while ((1 << n) < v) begin
        n = n + 1;
      end
      clog2f = n;
    end
  endfunction

  localparam OW  = clog2f(LBYTES);                   // byte offset width
  localparam BW  = clog2f(`DMC_WORD_BYTES);
  localparam WW  = OW - BW;                          // word-select bits
  localparam IW  = (LINES > 1) ? clog2f(LINES) : 1;
  localparam TW  = AW - IW - OW;
  localparam WYB = (WAYS > 1) ? clog2f(WAYS) : 1;
  // capacity = lines * line bytes, so index plus offset is its log2
  localparam CAP_LOG = IW + OW;

  // OW is a ceiling log2, so a line size that is not a power of two
  // would leave offsets at the top of each line that never map to a
  // stored byte; LINE_OK records whether the offset covers the line
  localparam LINE_OK = ((1 << OW) == LBYTES);

  // address layout with the default sizes (32-bit address, 16-byte
  // lines, 64 lines): tag in bits 31..10, index in bits 9..4, word in
  // bits 3..2 and byte-in-word in bits 1..0; consecutive memory lines
  // take consecutive index values and wrap after LINES of them

  // a bad line size leaves this marker block in the elaborated
  // hierarchy; it builds no logic, the offset arithmetic is simply wrong
  generate
    if (LINE_OK == 0) begin : g_line_size_not_pow2
    end
  endgenerate

  // field extraction: tag high, index middle, offset low
  function [TW-1:0] tag_of;
    input [AW-1:0] a;
    begin
      tag_of = a[AW-1:CAP_LOG];
    end
  endfunction

  function [IW-1:0] idx_of;
    input [AW-1:0] a;
    begin
      idx_of = a[CAP_LOG-1:OW];
    end
  endfunction

  function [WW-1:0] word_of;
    input [AW-1:0] a;
    begin
      word_of = a[OW-1:BW];
    end
  endfunction

  // way decode shared by the fill strobe and the modified-bit pointer
  function way_is;
    input [WYB-1:0] w;
    input integer   n;
    reg   [31:0]    nv;
    begin
      nv     = n;
      way_is = (w == nv[WYB-1:0]);
    end
  endfunction

  // physical mode looks up with the translated address; virtual with the raw one
  wire [AW-1:0] look_addr = virt_mode ? req_addr : req_paddr;

  reg  [TW-1:0]   ref_tag_ff;
  reg  [TW-1:0]   ref_ptag_ff;
  reg  [IW-1:0]   ref_idx_ff;
  reg  [WYB-1:0]  rr_ff;

  wire [WAYS-1:0]    way_match;
  wire [WAYS-1:0]    way_mod;
  wire [WAYS*DW-1:0] way_data;
  wire [WAYS-1:0]    ptag_match;

  // per-way fill strobes and physical shadow tag for alias checks
  genvar g;
  generate
    for (g = 0; g < WAYS; g = g + 1) begin : g_way
      wire sel     = way_is(fill_way[WYB-1:0], g);
      wire we      = fill_we & sel;
      wire tag_we  = we & fill_last;
      wire inval   = we & ~fill_last;
      wire msel    = way_is(rr_ff, g);
      wire [TW-1:0] stag;
      wire [TW-1:0] ptag_rd;
      reg  [LINES-1:0] pval_ff;

      dmc_way #(.TW(TW), .IW(IW), .WW(WW), .DW(DW), .LINES(LINES)) u_way (
        .clk               (clk),
        .sys_rst           (sys_rst),
        .rd_idx            (idx_of(look_addr)),
        .rd_word           (word_of(look_addr)),
        .cmp_tag           (ref_tag_ff),
        .cmp_idx           (ref_idx_ff),
        .fill_idx          (idx_of(fill_addr)),
        .fill_word         (word_of(fill_addr)),
        .fill_data         (fill_data),
        .fill_we           (we),
        .tag_we            (tag_we),
        .fill_tag          (tag_of(fill_addr)),
        .inval             (inval),
        .mod_set           (req_valid & req_write & msel & hit_ff & rsp_valid_ff),
        .mod_idx           (ref_idx_ff),
        .match             (way_match[g]),
        .line_modified_bit (way_mod[g]),
        .rd_data           (way_data[g*DW +: DW]),
        .stored_tag        (stag)
      );

      // physical shadow tags, second table for the aliasing cross-check;
      // indexed like the virtual tag store so both entries pair up
      dmc_mem #(.WIDTH(TW), .DEPTH(LINES), .AW(IW)) u_ptag (
        .clk        (clk),
        .rd_addr    (idx_of(look_addr)),
        .wr_addr    (idx_of(fill_addr)),
        .wr_en      (tag_we),
        .wr_data    (tag_of(fill_paddr)),
        .rd_data_ff (ptag_rd)
      );

      // shadow valid flags follow the way's own valid flags; without them
      // an unfilled shadow entry reads as unknown and fakes an alias
      always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          pval_ff <= {LINES{`DMC_VALID_RST}};
        end else if (tag_we) begin
          pval_ff[idx_of(fill_addr)] <= 1'b1;
        end else if (inval) begin
          pval_ff[idx_of(fill_addr)] <= 1'b0;
        end
      end

      // a physical match only counts on a committed line
      assign ptag_match[g] = pval_ff[ref_idx_ff] & (ptag_rd == ref_ptag_ff);
    end
  endgenerate

  // hit is the OR of way matches; decoder steers data from matching way
  reg          any_hit;
  reg          any_mod;
  reg [DW-1:0] sel_data;
  integer      k;
  always @* begin
    any_hit  = 1'b0;
    any_mod  = 1'b0;
    sel_data = {DW{1'b0}};
    for (k = 0; k < WAYS; k = k + 1) begin
      if (way_match[k]) begin
        any_hit  = 1'b1;
        any_mod  = way_mod[k];
        sel_data = way_data[k*DW +: DW];
      end
    end
  end

  // alias: physical tag matches but virtual tag does not, in virtual mode
  wire alias_now = virt_mode & ~any_hit & (|ptag_match);

  // way pointer for writes, held at way 0 by reset and every hit; replacement choice is outside
  // it only picks which way's modified flag a write reference marks
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rr_ff <= {WYB{1'b0}};
    end else if (rsp_valid_ff & any_hit) begin
      rr_ff <= {WYB{1'b0}};
    end
  end

  // pipeline, one reference per cycle if wanted:
  //   edge 1: request taken, tag, shadow and data stores read, fields
  //           of the reference latched, rsp_valid_ff raised
  //   edge 2: stored tag against latched tag and valid flag, data word
  //           steered; hit_ff, rd_data_ff, alias_ff and the modified
  //           flag registered together
  // both paths end in the same register stage, so the slower of the
  // data read and the compare sets the clock period
  // the requester keeps its own copy of a request it wants to retry
  // after a miss; nothing here is held for it
  // miss_paddr_ff keeps the translated address of the last request so
  // the memory side can start the fetch from it

  // latch reference fields the cycle the stores are read
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ref_tag_ff   <= {TW{1'b0}};
      ref_ptag_ff  <= {TW{1'b0}};
      ref_idx_ff   <= {IW{1'b0}};
      rsp_valid_ff <= 1'b0;
      miss_paddr_ff <= {AW{1'b0}};
    end else begin
      rsp_valid_ff <= req_valid;
      if (req_valid) begin
        ref_tag_ff    <= tag_of(look_addr);
        ref_ptag_ff   <= tag_of(req_paddr);
        ref_idx_ff    <= idx_of(look_addr);
        // translated address reaches the miss path in both modes
        miss_paddr_ff <= req_paddr;
      end
    end
  end

  // result registers: hit and data settle together, slower path sets the cycle
  // rd_data_ff loads the matching way's word every cycle and zero when no
  // way matches; only hit_ff says whether it is worth anything
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hit_ff               <= 1'b0;
      rd_data_ff           <= {DW{1'b0}};
      alias_ff             <= 1'b0;
      line_modified_bit_ff <= 1'b0;
    end else begin
      hit_ff               <= rsp_valid_ff & any_hit;
      rd_data_ff           <= sel_data;
      alias_ff             <= rsp_valid_ff & alias_now;
      line_modified_bit_ff <= rsp_valid_ff & any_mod;
    end
  end
  // a miss leaves hit low; rd_data_ff then carries zero from the data
  // steering and is discarded, the word comes from memory
  // alias_ff only flags the case; undoing the alias (flushing one of the
  // two lines) is left to the requester, as is keeping shared pages out
  // of the cache altogether
endmodule // dmc_cache

/* File: dmc_cache_monitor.sv */
// Purpose: port assertions for the cache lookup
// Assumes: one clock, reset clears all lines
// Notes:   bound to every dmc_cache
`timescale 1ns/100ps
module dmc_cache_monitor #(
  parameter AW = 32
) (
  input wire          clk,
  input wire          sys_rst,
  input wire          virt_mode,
  input wire          req_valid,
  input wire [AW-1:0] req_paddr,
  input wire          fill_we,
  input wire          fill_last,
  input wire          rsp_valid_ff,
  input wire          hit_ff,
  input wire          alias_ff,
  input wire          line_modified_bit_ff,
  input wire [AW-1:0] miss_paddr_ff
);
  reg any_fill_ff;
  // no hit is possible before a line is committed
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) any_fill_ff <= 1'b0;
    else if (fill_we && fill_last) any_fill_ff <= 1'b1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  rsp_after_req_a: assert property (req_valid |=> rsp_valid_ff)
    else $error("response missing");
  rsp_only_req_a: assert property (!req_valid |=> !rsp_valid_ff)
    else $error("response without request");
  hit_needs_req_a: assert property (hit_ff |-> $past(req_valid, 2))
    else $error("hit without request");
  hit_needs_fill_a: assert property (hit_ff |-> any_fill_ff)
    else $error("hit before any fill");
  cold_no_hit_a: assert property ($fell(sys_rst) |-> !hit_ff [*3])
    else $error("hit after reset");
  miss_addr_a: assert property (rsp_valid_ff |-> miss_paddr_ff == $past(req_paddr))
    else $error("miss address wrong");
  alias_virt_a: assert property (alias_ff |-> $past(virt_mode))
    else $error("alias outside virtual mode");
  mod_with_hit_a: assert property (line_modified_bit_ff |-> hit_ff)
    else $error("modified without hit");
  cover property (hit_ff);
  cover property (rsp_valid_ff ##1 !hit_ff);
  cover property (fill_we && fill_last);
endmodule // dmc_cache_monitor

bind dmc_cache dmc_cache_monitor #(.AW(AW)) i_mon (
  .clk(clk), .sys_rst(sys_rst), .virt_mode(virt_mode), .req_valid(req_valid),
  .req_paddr(req_paddr), .fill_we(fill_we), .fill_last(fill_last),
  .rsp_valid_ff(rsp_valid_ff), .hit_ff(hit_ff), .alias_ff(alias_ff),
  .line_modified_bit_ff(line_modified_bit_ff), .miss_paddr_ff(miss_paddr_ff)
);

/* File: dmc_cache_tb.sv */
// Purpose: self-checking bench for the cache lookup
// Assumes: four lines of 16 bytes, one way, paddr equals vaddr
// Notes:   tag and valid model predicts every hit
`timescale 1ns/100ps
module dmc_cache_tb;
  localparam LN = 4;
  reg          clk, sys_rst, virt_mode, req_valid, go;
  reg  [31:0]  req_addr, req_paddr, base;
  wire         fill_we, fill_last, busy, rsp_valid_ff, hit_ff, alias_ff, mod_ff;
  wire [31:0]  fill_addr, fill_paddr, fill_data, rd_data_ff, miss_paddr_ff;
  reg  [25:0]  tag_m [0:LN-1];
  reg          val_m [0:LN-1];
  integer      fails, checks, cyc, seed, i, k, r;

  dmc_mem_model i_mem (
    .clk(clk), .go(go), .base(base), .fill_we(fill_we), .fill_last(fill_last),
    .fill_addr(fill_addr), .fill_paddr(fill_paddr), .fill_data(fill_data), .busy(busy)
  );
  dmc_cache #(.LINES(LN)) i_dut (
    .clk(clk), .sys_rst(sys_rst), .virt_mode(virt_mode), .req_valid(req_valid),
    .req_addr(req_addr), .req_paddr(req_paddr), .req_write(1'b0), .fill_we(fill_we),
    .fill_addr(fill_addr), .fill_paddr(fill_paddr), .fill_data(fill_data),
    .fill_last(fill_last), .fill_way(8'h00), .rsp_valid_ff(rsp_valid_ff),
    .hit_ff(hit_ff), .rd_data_ff(rd_data_ff), .alias_ff(alias_ff),
    .line_modified_bit_ff(mod_ff), .miss_paddr_ff(miss_paddr_ff)
  );
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // hang guard, far above the expected run
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      $display("timeout");
      fails = fails + 1;
      complete_run;
    end
  end
  task chk(input [39:0] nm, input [31:0] seen, input [31:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("CHECK FAILED %0s exp %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task rst;
    begin
      sys_rst = 1'b1;
      repeat (8) @(negedge clk);
      sys_rst = 1'b0;
      for (k = 0; k < LN; k = k + 1) val_m[k] = 1'b0;
    end
  endtask
  // one lookup, then a line fill on a miss
  task look(input [31:0] a);
    reg ex;
    begin
      ex = val_m[a[5:4]] && tag_m[a[5:4]] == a[31:6];
      req_valid = 1'b1;
      req_addr = a;
      req_paddr = a;  // one name per physical line, no aliases
      @(negedge clk);
      chk("rsp", rsp_valid_ff, 1);
      req_valid = 1'b0;
      req_addr = ~a;
      req_paddr = ~a;
      @(negedge clk);
      chk("rsp0", rsp_valid_ff, 0);
      chk("maddr", miss_paddr_ff, a);
      chk("hit", hit_ff, ex);
      chk("alias", alias_ff, 0);
      chk("mod", mod_ff, 0);
      if (ex) chk("data", rd_data_ff, i_mem.mw(a));
      if (!ex) begin
        base = {a[31:4], 4'h0};
        go = 1'b1;
        @(negedge clk);
        go = 1'b0;
        for (k = 0; k < 20 && busy; k = k + 1) @(negedge clk);
        val_m[a[5:4]] = 1'b1;
        tag_m[a[5:4]] = a[31:6];
      end
    end
  endtask
  task complete_run;
    begin
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  initial begin
    fails = 0;
    checks = 0;
    cyc = 0;
    seed = 32'h8eb1_83e7;
    virt_mode = 1'b0;
    req_valid = 1'b0;
    go = 1'b0;
    base = 32'h0000_0000;
    req_addr = 32'h0000_0000;
    req_paddr = 32'h0000_0000;
    rst;
    for (i = 0; i < LN; i = i + 1) look(i * 16);
    $display("test cold done");
    for (i = 0; i < 4; i = i + 1) look(32'h0000_0040 + i * 4);
    look(32'h0000_0000);
    look(32'h0000_0040);
    $display("test wrap done");
    for (i = 0; i < 60; i = i + 1) begin
      r = $random(seed);
      virt_mode = r[0];
      look($random(seed) & 32'h0000_00fc);
    end
    $display("test random done");
    rst;
    look(32'h0000_0040);
    $display("test reset done");
    complete_run;
  end
endmodule // dmc_cache_tb

/* File: dmc_consts.vh */
// Purpose: constants for the cache lookup block
// Assumes: byte addresses, 32-bit words
// Notes:   widths derived from these in the modules
`ifndef DMC_CONSTS_VH
`define DMC_CONSTS_VH
`define DMC_ADDR_W      32
`define DMC_DATA_W      32
`define DMC_LINE_BYTES  16
`define DMC_NUM_LINES   64
`define DMC_NUM_WAYS    1
`define DMC_WORD_BYTES  4
`define DMC_VALID_RST   1'b0
`define DMC_MOD_RST     1'b0
`define DMC_MODE_PHYS   1'b0
`define DMC_MODE_VIRT   1'b1
`endif

/* File: dmc_mem.v */
// Purpose: two-port (one read, one write) synchronous memory with registered read data
// Assumes: single clock, write and read in the same cycle allowed
// Notes:   read shows old contents on a same-address write
`timescale 1ns/100ps
module dmc_mem #(
  parameter WIDTH = 32,
  parameter DEPTH = 64,
  parameter AW    = 6
) (
  input  wire             clk,
  input  wire [AW-1:0]    rd_addr,
  input  wire [AW-1:0]    wr_addr,
  input  wire             wr_en,
  input  wire [WIDTH-1:0] wr_data,
  output reg  [WIDTH-1:0] rd_data_ff
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];

  // no reset on storage; validity lives in separate flags
  always @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data_ff <= mem[rd_addr];
  end
endmodule // dmc_mem

/* File: dmc_mem_model.sv */
// Purpose: main memory side, streams one line into the fill port
// Assumes: four 32-bit words a line, data fixed by address
// Notes:   words sent last first; idle fill_addr and fill_data scrambled
`timescale 1ns/100ps
module dmc_mem_model #(
  parameter WORDS = 4
) (
  input  wire        clk,
  input  wire        go,
  input  wire [31:0] base,
  output reg         fill_we,
  output reg         fill_last,
  output reg  [31:0] fill_addr,
  output reg  [31:0] fill_paddr,
  output reg  [31:0] fill_data,
  output reg         busy
);
  integer k;
  // memory contents
  function [31:0] mw(input [31:0] a);
    mw = a ^ 32'hc3a5_0f1e;
  endfunction
  initial begin
    fill_we = 1'b0;
    fill_last = 1'b0;
    busy = 1'b0;
    fill_addr = 32'h0000_0000;
    fill_paddr = 32'h0000_0000;
    fill_data = 32'h0000_0000;
  end
  // whole line per miss, reversed to show word order is free
  always @(posedge go) begin
    busy = 1'b1;
    for (k = WORDS - 1; k >= 0; k = k - 1) begin
      @(negedge clk);
      fill_we = 1'b1;
      fill_addr = base + 4 * k;
      fill_paddr = base;
      fill_data = mw(base + 4 * k);
      fill_last = (k == 0);
    end
    @(negedge clk);
    fill_we = 1'b0;
    fill_last = 1'b0;
    fill_addr = ~fill_addr;  // released, no stale value
    fill_data = ~fill_data;
    busy = 1'b0;
  end
endmodule // dmc_mem_model

/* File: dmc_way.v */
// Purpose: one way of the cache: tag store, status flags, data store, compare
// Assumes: fill writes one word per cycle into the addressed line
// Notes:   status flags are flops so that reset clears them at once
`timescale 1ns/100ps
`include "dmc_consts.vh"
module dmc_way #(
  parameter TW    = 26,
  parameter IW    = 2,
  parameter WW    = 2,
  parameter DW    = 32,
  parameter LINES = 4
) (
  input  wire          clk,
  input  wire          sys_rst,
  input  wire [IW-1:0] rd_idx,
  input  wire [WW-1:0] rd_word,
  input  wire [TW-1:0] cmp_tag,
  input  wire [IW-1:0] cmp_idx,
  input  wire [IW-1:0] fill_idx,
  input  wire [WW-1:0] fill_word,
  input  wire [DW-1:0] fill_data,
  input  wire          fill_we,
  input  wire          tag_we,
  input  wire [TW-1:0] fill_tag,
  input  wire          inval,
  input  wire          mod_set,
  input  wire [IW-1:0] mod_idx,
  output wire          match,
  output wire          line_modified_bit,
  output wire [DW-1:0] rd_data,
  output wire [TW-1:0] stored_tag
);
  reg [LINES-1:0] valid_ff;
  reg [LINES-1:0] mod_ff;

  // tag store, indexed by the index field alone
  dmc_mem #(.WIDTH(TW), .DEPTH(LINES), .AW(IW)) u_tag (
    .clk        (clk),
    .rd_addr    (rd_idx),
    .wr_addr    (fill_idx),
    .wr_en      (tag_we),
    .wr_data    (fill_tag),
    .rd_data_ff (stored_tag)
  );

  // data store, indexed by index and word offset together
  dmc_mem #(.WIDTH(DW), .DEPTH(LINES << WW), .AW(IW + WW)) u_data (
    .clk        (clk),
    .rd_addr    ({rd_idx, rd_word}),
    .wr_addr    ({fill_idx, fill_word}),
    .wr_en      (fill_we),
    .wr_data    (fill_data),
    .rd_data_ff (rd_data)
  );

  // status flags; reset clears every valid bit so nothing hits unfilled
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      valid_ff <= {LINES{`DMC_VALID_RST}};
      mod_ff   <= {LINES{`DMC_MOD_RST}};
    end else begin
      if (inval) begin
        valid_ff[fill_idx] <= 1'b0;
      end
      if (tag_we) begin
        valid_ff[fill_idx] <= 1'b1;
        mod_ff[fill_idx]   <= 1'b0;
      end
      if (mod_set) begin
        mod_ff[mod_idx] <= 1'b1; // set wins over the fill clear
      end
    end
  end

  // compare runs beside the data read, both settle in the same cycle
  assign match             = valid_ff[cmp_idx] & (stored_tag == cmp_tag);
  assign line_modified_bit = mod_ff[cmp_idx];
endmodule // dmc_way
